// *** hdl/efc_core.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "efc_defs.svh"
module efc_core
  import efc_pkg::*;
(
  input wire logic ref_clk_in, // 25 MHz clock
  input wire logic rst_n_in, // Sync reset, active low
  input wire logic sw_reset_in, // Soft reset pulse from command decoder
  input wire logic reg_wr_in, // Register write strobe
  input wire logic reg_rd_in, // Register read strobe
  input wire logic [7:0] reg_addr_in, // Register address
  input wire logic [7:0] reg_wdata_in, // Write data
  input wire logic chk_ok_in, // Write carried a valid checksum
  input wire logic chk_bad_in, // Received checksum byte was wrong
  output logic [7:0] rd_data_out, // Read data, valid cycle after strobe
  output logic checksum_enable_out, // Checksum mode active
  input wire logic [4:0] err_cond_in, // Raw error conditions, async
  input wire logic buf_internal_in, // Internal buffer timer active
  input wire logic [2:0] mux_field_in, // Gain register mux field
  input wire logic [6:0] gp_dir_in, // Pin directions, 1 = output
  input wire logic [6:0] gp_data_in, // Plain pin output data
  input wire logic [6:0] gp_pin_in, // Pin levels, async
  output logic [6:0] gp_pin_out, // Pin drive values
  output logic [6:0] gp_pin_oe_out, // Pin drive enables
  output logic buffer_active_out, // Buffer active, high = active
  output logic error_summary_out, // Summary of unmasked errors
  output logic op_tick_out // Operating clock tick, one cycle
);
  logic [7:0] mask_ff, time_ff, pfn_ff;
  logic [7:0] err_ff;
  logic [4:0] cond_s1_ff, cond_s2_ff;
  logic [6:0] pin_s1_ff, pin_s2_ff, pin_d_ff;
  logic [4:0] div_ff;
  logic tick_ff, osc_lvl;
  logic [6:0] sup_lim;
  logic [4:0] qual;
  logic [6:0] sup_ff [5];
  logic blocked, buf_act;
  efc_trg_t trg_ff;
  logic [7:0] tcnt_ff;
  logic ltd, edb, pol, muxd, wr_time, wr_err;
  logic summary;

  assign ltd = time_ff[`EFC_BIT_LTD];
  assign edb = mask_ff[`EFC_BIT_EDB];
  assign pol = mask_ff[`EFC_BIT_POL];
  assign muxd = mask_ff[`EFC_BIT_MUXD];
  assign wr_time = reg_wr_in && reg_addr_in == `EFC_OFS_TIME;
  assign wr_err = reg_wr_in && reg_addr_in == `EFC_OFS_ERR;

  // Config registers; soft reset acts like power-on
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in || sw_reset_in) begin // see R13
      mask_ff <= `EFC_RST_MASK;
      time_ff <= `EFC_RST_TIME;
      pfn_ff <= `EFC_RST_PFN;
    end else if (reg_wr_in) begin
      if (reg_addr_in == `EFC_OFS_MASK) begin
        mask_ff <= reg_wdata_in;
      end else if (reg_addr_in == `EFC_OFS_TIME) begin
        time_ff <= reg_wdata_in & 8'hbd;
        // Enabling needs a good checksum; clearing never does
        if (reg_wdata_in[0] && !chk_ok_in && !time_ff[`EFC_BIT_CHK]) begin // see R11 R12
          time_ff[`EFC_BIT_CHK] <= 1'b0;
        end
      end else if (reg_addr_in == `EFC_OFS_PFN) begin
        pfn_ff <= reg_wdata_in;
      end
    end
  end
  assign checksum_enable_out = time_ff[`EFC_BIT_CHK];

  // Two-stage synchronisers for analog conditions and pins
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      cond_s1_ff <= 5'h00;
      cond_s2_ff <= 5'h00;
      pin_s1_ff <= 7'h00;
      pin_s2_ff <= 7'h00;
      pin_d_ff <= 7'h00;
    end else begin
      cond_s1_ff <= err_cond_in;
      cond_s2_ff <= cond_s1_ff;
      pin_s1_ff <= gp_pin_in;
      pin_s2_ff <= pin_s1_ff;
      pin_d_ff <= pin_s2_ff;
    end
  end

  // Operating tick: internal divider, or pin six rising edge
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      div_ff <= 5'h00;
      tick_ff <= 1'b0;
    end else begin
      div_ff <= (div_ff == 5'(`EFC_TICK_DIV - 1)) ? 5'h00 : div_ff + 5'h01;
      if (pfn_ff[`EFC_BIT_SYNC] && !gp_dir_in[6]) begin // see R15
        tick_ff <= pin_s2_ff[6] && !pin_d_ff[6];
      end else begin
        tick_ff <= div_ff == 5'(`EFC_TICK_DIV - 1); // see R10
      end
    end
  end
  assign op_tick_out = tick_ff;
  // Roughly half duty; the divide by 25 cannot be exactly even
  assign osc_lvl = div_ff < 5'(`EFC_TICK_DIV / 2);

  // Suppression code to tick count
  always_comb begin
    case (time_ff[5:2]) // see R8
      4'h9: sup_lim = 7'd12;
      4'ha: sup_lim = 7'd16;
      4'hb: sup_lim = 7'd24;
      4'hc: sup_lim = 7'd32;
      4'hd: sup_lim = 7'd48;
      4'he: sup_lim = 7'd64;
      4'hf: sup_lim = 7'd127;
      default: sup_lim = {3'h0, time_ff[5:2]};
    endcase
  end

  // Buffer trigger sequencer on pin four
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in || sw_reset_in) begin
      trg_ff <= TRG_IDLE;
      tcnt_ff <= 8'h00;
    end else begin
      case (trg_ff)
        TRG_IDLE: begin
          tcnt_ff <= 8'h00;
          if (pfn_ff[`EFC_BIT_TRIG] && !gp_dir_in[4] && pin_s2_ff[4] && !pin_d_ff[4]) begin
            trg_ff <= TRG_DELAY; // see R17
          end
        end
        TRG_DELAY: begin
          if (tick_ff) begin
            tcnt_ff <= tcnt_ff + 8'h01;
          end
          // Fourth tick ends the wait: the first may come at once, so 3 to 4 periods
          if (tick_ff && tcnt_ff == 8'(`EFC_TRIG_TICKS)) begin
            trg_ff <= TRG_HOLD;
            tcnt_ff <= 8'h00;
          end
        end
        TRG_HOLD: begin
          if (!pin_s2_ff[4]) begin
            trg_ff <= TRG_TAIL; // see R18
          end
        end
        default: begin
          if (pin_s2_ff[4]) begin
            trg_ff <= TRG_HOLD;
            tcnt_ff <= 8'h00;
          end else if (tick_ff) begin
            tcnt_ff <= tcnt_ff + 8'h01;
            if (tcnt_ff >= 8'(`EFC_TRIG_TICKS) + {1'b0, sup_lim}) begin // see R18
              trg_ff <= TRG_IDLE;
            end
          end
        end
      endcase
    end
  end
  assign buf_act = buf_internal_in || trg_ff == TRG_HOLD || trg_ff == TRG_TAIL;
  assign buffer_active_out = buf_act;
  assign blocked = buf_act && !edb; // see R3

  // Per-source suppression: condition must persist the programmed ticks
  for (genvar i = 0; i < 5; i++) begin : g_sup
    always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in || !cond_s2_ff[i] || blocked) begin
        sup_ff[i] <= 7'h00; // see R9
      end else if (tick_ff && sup_ff[i] < sup_lim) begin
        sup_ff[i] <= sup_ff[i] + 7'h01;
      end
    end
    assign qual[i] = cond_s2_ff[i] && !blocked && sup_ff[i] >= sup_lim;
  end

  // Error status: set wins over write-one clear; real time when latch off
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in || sw_reset_in) begin
      err_ff <= 8'h00;
    end else begin
      err_ff[`EFC_BIT_CHKF] <= (time_ff[`EFC_BIT_CHK] && chk_bad_in)
        || (err_ff[`EFC_BIT_CHKF] && !(wr_err && reg_wdata_in[7])); // see R22 R21
      if (ltd) begin
        {err_ff[6], err_ff[4], err_ff[2:0]} <= qual; // see R6
      end else begin
        {err_ff[6], err_ff[4], err_ff[2:0]} <= qual | ({err_ff[6], err_ff[4], err_ff[2:0]}
          & ~({5{wr_err}} & {reg_wdata_in[6], reg_wdata_in[4], reg_wdata_in[2:0]})); // see R21
      end
    end
  end

  // Summary ignores checksum fault and masked sources
  assign summary = |({err_ff[6], err_ff[4], err_ff[2:0]}
    & ~{mask_ff[6], mask_ff[4], mask_ff[2:0]}); // see R4
  assign error_summary_out = summary; // see R5

  // Pin routing; direction bit gates every drive
  always_comb begin
    gp_pin_oe_out = gp_dir_in; // see R23
    gp_pin_out = gp_data_in;
    for (int k = 0; k < 3; k++) begin
      if (pfn_ff[k] && !muxd) begin // see R1 R20
        gp_pin_out[k] = mux_field_in[k];
      end
    end
    if (pfn_ff[`EFC_BIT_EF]) begin
      gp_pin_out[3] = summary; // see R19
    end
    if (pfn_ff[`EFC_BIT_BUFO]) begin
      gp_pin_out[5] = buf_act ^ pol; // see R16 R2
    end
    if (pfn_ff[`EFC_BIT_OSC]) begin
      gp_pin_out[6] = osc_lvl; // see R14
    end
  end

  // Read port; unmapped addresses read zero
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      rd_data_out <= 8'h00;
    end else if (reg_rd_in) begin
      if (reg_addr_in == `EFC_OFS_MASK) begin
        rd_data_out <= mask_ff;
      end else if (reg_addr_in == `EFC_OFS_TIME) begin
        rd_data_out <= time_ff;
      end else if (reg_addr_in == `EFC_OFS_PFN) begin
        rd_data_out <= pfn_ff;
      end else if (reg_addr_in == `EFC_OFS_ERR) begin
        rd_data_out <= {err_ff[7:6], buf_act, err_ff[4], summary, err_ff[2:0]};
      end else begin
        rd_data_out <= 8'h00;
      end
    end
  end

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);

  a_chk_needs_ok: assert property (wr_time && reg_wdata_in[0] && !chk_ok_in // see R12
    && !checksum_enable_out && !sw_reset_in |=> !checksum_enable_out)
    else $error("checksum enabled without valid checksum");
  a_chk_soft_rst: assert property (sw_reset_in |=> !checksum_enable_out) // see R13
    else $error("soft reset left checksum mode on");
  a_chk_fault_set: assert property (checksum_enable_out && chk_bad_in && !sw_reset_in // see R22
    |=> err_ff[7]) else $error("checksum fault not flagged");
  a_flag_sticky: assert property (!ltd && err_ff[0] && !wr_err && !sw_reset_in // see R21
    |=> err_ff[0]) else $error("latched flag lost without clear");
  a_mask_summary: assert property (mask_ff[2:0] == 3'h7 && mask_ff[6] && mask_ff[4] // see R4
    |-> !error_summary_out) else $error("masked error reached summary");
  a_buf_blocks: assert property (blocked && !err_ff[0] |=> !err_ff[0] && sup_ff[0] == 7'h00) // see R3
    else $error("detection not suppressed while buffer active");
  a_trig_delay: assert property (trg_ff == TRG_DELAY ##1 trg_ff == TRG_HOLD |-> // see R17
    $past(tcnt_ff) == 8'h03) else $error("trigger started buffer without full delay");
  a_trig_start: assert property (trg_ff == TRG_DELAY ##1 trg_ff == TRG_HOLD // see R17
    |-> $past(tick_ff)) else $error("trigger delay ended off a tick");
  a_sup_zero: assert property (time_ff[5:2] == 4'h0 && cond_s2_ff[1] && !blocked // see R8
    && !sw_reset_in |=> err_ff[1]) else $error("zero suppression still delayed flag");
  a_pin_oe: assert property (gp_pin_oe_out == gp_dir_in) // see R23
    else $error("pin enable differs from direction");
  a_mux_off: assert property (muxd && !pfn_ff[`EFC_BIT_EF] |-> gp_pin_out[2:0] // see R1
    == gp_data_in[2:0]) else $error("mux pins driven while disabled");

  c_trig_cycle: cover property (trg_ff == TRG_TAIL ##[1:300] trg_ff == TRG_IDLE);
  c_chk_on: cover property (wr_time && chk_ok_in && reg_wdata_in[0] ##1 checksum_enable_out);
  c_summary: cover property ($rose(error_summary_out));
  c_realtime: cover property (ltd && $fell(err_ff[0]));
endmodule : efc_core
`default_nettype wire

// *** pkg/efc_defs.svh ***
// Contract
// R1 - Mux disable bit stops mux pin drive
// R2 - Polarity bit selects buffer indication level
// R3 - Buffer active suppresses detection unless overridden
// R4 - Unmasked five errors OR into summary
// R5 - Summary output is active high
// R6 - Latch disable gives real-time suppressed flags
// R7 - Host clears flags after setting latch disable
// R8 - Suppression code maps to cycle counts
// R9 - Suppression starts at buffer end or event
// R10 - Suppression counts nominal 1 MHz clock ticks
// R11 - Bit 0 write enables checksum mode
// R12 - Enabling write must carry valid checksum
// R13 - Software or power reset clears checksum mode
// R14 - Oscillator function drives pin six output
// R15 - External clock function takes pin six
// R16 - Buffer indicator on pin five, polarity
// R17 - Trigger rising edge starts buffer, 3-4 ticks
// R18 - Buffer holds while high, then extends
// R19 - Summary function drives pin three
// R20 - Mux route bits drive pins from gain
// R21 - Flags set on event, clear by one
// R22 - Bad checksum sets checksum fault flag
// R23 - Direction bit 0 input, 1 output
`ifndef EFC_DEFS_SVH
`define EFC_DEFS_SVH
`define EFC_OFS_ERR 8'h04
`define EFC_OFS_MASK 8'h0a
`define EFC_OFS_TIME 8'h0b
`define EFC_OFS_PFN 8'h0c
`define EFC_RST_MASK 8'h00
`define EFC_RST_TIME 8'h10
`define EFC_RST_PFN 8'h00
`define EFC_BIT_MUXD 7
`define EFC_BIT_POL 5
`define EFC_BIT_EDB 3
`define EFC_BIT_LTD 7
`define EFC_BIT_CHK 0
`define EFC_BIT_OSC 7
`define EFC_BIT_SYNC 6
`define EFC_BIT_BUFO 5
`define EFC_BIT_TRIG 4
`define EFC_BIT_EF 3
`define EFC_BIT_CHKF 7
`define EFC_BIT_BUFFER_ACTIVE 5
`define EFC_CLK_HZ 25000000
`define EFC_TICK_HZ 1000000
`define EFC_TICK_DIV (`EFC_CLK_HZ / `EFC_TICK_HZ)
`define EFC_TRIG_TICKS 3
`endif

// *** pkg/efc_pkg.sv ***
package efc_pkg;
  // Trigger sequencer states
  typedef enum logic [1:0] {TRG_IDLE, TRG_DELAY, TRG_HOLD, TRG_TAIL} efc_trg_t;
endpackage : efc_pkg

// *** tb/efc_host_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module efc_host_model (
  input wire logic clk_in, // Bus clock
  input wire logic [7:0] rd_data_in, // Read data from device
  output logic wr_out, // Write strobe
  output logic rd_out, // Read strobe
  output logic [7:0] addr_out, // Register address
  output logic [7:0] wdata_out, // Write data
  output logic chk_ok_out, // Frame carried a valid checksum
  output logic chk_bad_out, // Checksum byte was wrong
  output logic sw_reset_out // Soft reset command
);
  // Idle bus; each task starts on an edge so no signal is driven twice in one step
  initial begin
    {wr_out, rd_out, chk_ok_out, chk_bad_out, sw_reset_out} = 5'h00;
    addr_out = 8'h00;
    wdata_out = 8'h00;
  end
  // One-byte write; the checksum verdict travels with the strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic ok);
    @(posedge clk_in);
    wr_out <= 1'b1;
    addr_out <= a;
    wdata_out <= d;
    chk_ok_out <= ok;
    @(posedge clk_in);
    wr_out <= 1'b0;
    chk_ok_out <= 1'b0;
    addr_out <= ~a; // Released bus shows no stale value
    wdata_out <= ~d;
    @(posedge clk_in); // Caller then sees the state the write left
  endtask : wr
  // Read; data stands from the edge that samples the strobe, taken one edge on
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_in);
    rd_out <= 1'b1;
    addr_out <= a;
    @(posedge clk_in);
    rd_out <= 1'b0;
    addr_out <= ~a;
    @(posedge clk_in);
    d = rd_data_in;
  endtask : rd
  // One-cycle pulses: soft reset (sel 1) or bad checksum byte (sel 0)
  task automatic pulse(input logic sel);
    @(posedge clk_in);
    if (sel) sw_reset_out <= 1'b1;
    else chk_bad_out <= 1'b1;
    @(posedge clk_in);
    sw_reset_out <= 1'b0;
    chk_bad_out <= 1'b0;
    @(posedge clk_in); // Caller then sees the effect of the pulse
  endtask : pulse
endmodule : efc_host_model
`default_nettype wire

// *** tb/error_flag_and_pin_function_config_tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none
module error_flag_and_pin_function_config_tb_top;
  logic ref_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic wr, rd, ok, bad, swr, chk_en, buffer_active, esum, tick;
  logic [7:0] addr, wdata, rdata, v;
  logic [4:0] err = 5'h00;
  logic bufi = 1'b0;
  logic [2:0] mux = 3'b000;
  logic [6:0] dir = 7'h00, gdat = 7'h2a, gpin = 7'h00, gpo, goe;
  int bad_count = 0, n_checks = 0, cyc = 0, c;
  // 25 MHz clock
  always #20 ref_clk_in = ~ref_clk_in;
  efc_host_model efc_host_model_i (.clk_in(ref_clk_in), .rd_data_in(rdata), .wr_out(wr),
    .rd_out(rd), .addr_out(addr), .wdata_out(wdata), .chk_ok_out(ok), .chk_bad_out(bad),
    .sw_reset_out(swr));
  efc_core efc_core_i (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .sw_reset_in(swr),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .chk_ok_in(ok), .chk_bad_in(bad), .rd_data_out(rdata), .checksum_enable_out(chk_en),
    .err_cond_in(err), .buf_internal_in(bufi), .mux_field_in(mux), .gp_dir_in(dir),
    .gp_data_in(gdat), .gp_pin_in(gpin), .gp_pin_out(gpo), .gp_pin_oe_out(goe),
    .buffer_active_out(buffer_active), .error_summary_out(esum), .op_tick_out(tick));
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up
  // Called at an edge, so the value seen is the one settled in the cycle before
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic rdc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] exp);
    efc_host_model_i.rd(a, v);
    chk(v & m, exp);
  endtask : rdc
  task automatic w(input int n);
    repeat (n) @(posedge ref_clk_in);
  endtask : w
  // Counts ticks (osc 0) or high cycles of the oscillator pin (osc 1)
  task automatic cnt(input int n, input logic osc, output int k);
    k = 0;
    repeat (n) begin
      @(posedge ref_clk_in);
      k += osc ? int'(gpo[6] === 1'b1) : int'(tick === 1'b1);
    end
  endtask : cnt
  // Holds the condition bits e for n cycles, then clears them and waits 10 cycles
  task automatic pulse_err(input logic [4:0] e, input int n);
    err <= e;
    w(n);
    err <= 5'h00;
    w(10);
  endtask : pulse_err
  // Hang guard, well above the length of the sequence
  always @(posedge ref_clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      bad_count++;
      wrap_up();
    end
  end
  initial begin
    w(16);
    rst_n_in <= 1'b1;
    rdc(8'h0a, 8'hff, 8'h00);
    rdc(8'h0b, 8'hff, 8'h10);
    rdc(8'h0c, 8'hff, 8'h00);
    rdc(8'h04, 8'hff, 8'h00);
    rdc(8'h3c, 8'hff, 8'h00);
    efc_host_model_i.wr(8'h0b, 8'h11, 1'b0);
    rdc(8'h0b, 8'hff, 8'h10);
    efc_host_model_i.wr(8'h0b, 8'h11, 1'b1);
    chk({7'h00, chk_en}, 8'h01);
    efc_host_model_i.pulse(1'b0);
    rdc(8'h04, 8'h80, 8'h80);
    efc_host_model_i.pulse(1'b1);
    chk({7'h00, chk_en}, 8'h00);
    dir <= 7'h7f;
    mux <= 3'b101;
    efc_host_model_i.wr(8'h0c, 8'h07, 1'b0);
    chk({5'h00, gpo[2:0]}, 8'h05);
    efc_host_model_i.wr(8'h0a, 8'h80, 1'b0);
    chk({5'h00, gpo[2:0]}, 8'h02);
    bufi <= 1'b1;
    efc_host_model_i.wr(8'h0c, 8'h28, 1'b0);
    chk({7'h00, gpo[5]}, 8'h01);
    efc_host_model_i.wr(8'h0a, 8'h20, 1'b0);
    chk({7'h00, gpo[5]}, 8'h00);
    bufi <= 1'b0;
    w(1);
    chk({7'h00, gpo[5]}, 8'h01);
    efc_host_model_i.wr(8'h0a, 8'h00, 1'b0);
    efc_host_model_i.wr(8'h0b, 8'h00, 1'b0);
    for (int i = 0; i < 5; i++) begin
      pulse_err(5'h01 << i, 100);
      rdc(8'h04, 8'hdf, 8'h08 | ((i < 3) ? (8'h01 << i) : ((i == 3) ? 8'h10 : 8'h40)));
      chk({6'h00, gpo[3], esum}, 8'h03);
      efc_host_model_i.wr(8'h0a, 8'h01 << ((i < 3) ? i : 2 * i - 2), 1'b0);
      chk({7'h00, esum}, 8'h00);
      efc_host_model_i.wr(8'h04, 8'hff, 1'b0);
      efc_host_model_i.wr(8'h0a, 8'h00, 1'b0);
      rdc(8'h04, 8'hff, 8'h00);
    end
    bufi <= 1'b1;
    pulse_err(5'h01, 100);
    bufi <= 1'b0;
    w(200);
    rdc(8'h04, 8'hff, 8'h00);
    efc_host_model_i.wr(8'h0a, 8'h08, 1'b0);
    bufi <= 1'b1;
    pulse_err(5'h01, 100);
    rdc(8'h04, 8'h01, 8'h01);
    bufi <= 1'b0;
    efc_host_model_i.wr(8'h04, 8'hff, 1'b0);
    efc_host_model_i.wr(8'h0b, 8'h24, 1'b0);
    pulse_err(5'h01, 225);
    rdc(8'h04, 8'h01, 8'h00);
    pulse_err(5'h01, 400);
    rdc(8'h04, 8'h01, 8'h01);
    efc_host_model_i.wr(8'h0b, 8'h80, 1'b0);
    efc_host_model_i.wr(8'h04, 8'hff, 1'b0);
    err <= 5'h01;
    w(50);
    rdc(8'h04, 8'h01, 8'h01);
    err <= 5'h00;
    w(50);
    rdc(8'h04, 8'h01, 8'h00);
    efc_host_model_i.wr(8'h0b, 8'h00, 1'b0);
    cnt(250, 1'b0, c);
    chk(8'(c), 8'h0a);
    dir <= 7'h40;
    efc_host_model_i.wr(8'h0c, 8'h80, 1'b0);
    cnt(25, 1'b1, c);
    chk(8'(c), 8'h0c);
    chk({1'b0, goe}, 8'h40);
    dir <= 7'h00;
    efc_host_model_i.wr(8'h0c, 8'h40, 1'b0);
    fork
      cnt(215, 1'b0, c);
      repeat (40) begin
        w(5);
        gpin[6] <= ~gpin[6];
      end
    join
    chk(8'(c), 8'h14);
    efc_host_model_i.wr(8'h0c, 8'h10, 1'b0);
    gpin[4] <= 1'b1;
    w(30);
    chk({7'h00, buffer_active}, 8'h00);
    w(100);
    chk({7'h00, buffer_active}, 8'h01);
    w(100);
    gpin[4] <= 1'b0;
    w(40);
    chk({7'h00, buffer_active}, 8'h01);
    w(200);
    chk({7'h00, buffer_active}, 8'h00);
    wrap_up();
  end
endmodule : error_flag_and_pin_function_config_tb_top
`default_nettype wire
